// [core/ddr_cmd_timer.sv]
`timescale 1ns/1ns
// Overview of operation
// R1 - A row stays open at least 40 ns before precharge and is precharged within 70,000 ns.
// R2 - Two ACTIVE or AUTO REFRESH commands to one bank are at least 55 ns apart.
// R3 - After AUTO REFRESH nothing is issued for 70 ns, or 120 ns on the largest module.
// R4 - READ or WRITE to a bank waits at least 15 ns after that bank's ACTIVE.
// R5 - READ with auto precharge waits at least 15 ns after the ACTIVE that opened the row.
// R6 - ACTIVE commands to different banks are at least 10 ns apart.
// R7 - After LOAD MODE REGISTER nothing is issued for the 2 ns mode cycle.
// R8 - The first latching strobe edge of a write lies 0.72 to 1.28 clocks after WRITE.
// R9 - Each falling strobe edge lies at least 0.2 clocks from the rising clock on each side.
// R10 - The strobe preamble is low at least 0.25 clocks and starts no earlier than the WRITE edge.
// R11 - AUTO REFRESH is issued at least every 70.3 us and never postponed or bursted past eight.
// R12 - A READ waits at least 2 clocks after the last write data.
// R13 - Every nanosecond minimum becomes whole clock cycles, rounded up at the clock in use.
module ddr_cmd_timer #(
    parameter int BURST_LEN  = ddr_timing_pkg::BURST_LEN_DEF,
    parameter bit BIG_MODULE = 1'b0
) (
    input  wire logic                               mclk_in,
    input  wire logic                               resetn_in,
    input  wire ddr_timing_pkg::req_s               req_in,
    output logic                                    req_ready_out,
    output logic                                    ck_out,
    output logic                                    ck_n_out,
    output logic                                    cke_out,
    output ddr_timing_pkg::cmd_pins_s               cmd_out,
    output logic [ddr_timing_pkg::BANK_W-1:0]       ba_out,
    output logic [ddr_timing_pkg::ADDR_W-1:0]       addr_out,
    output logic                                    dqs_out,
    output logic                                    dqs_oe_out,
    input  wire logic                               dqs_in
);
    import ddr_timing_pkg::*;

    typedef logic [CNT_W-1:0] cnt_t;

    // R13
    localparam cnt_t RAS_MIN_CK = cnt_t'(ns_to_ck_min(TRAS_MIN_NS));
    // Loaded one short so the forced precharge still lands inside the limit
    localparam cnt_t RAS_MAX_CK = cnt_t'(ns_to_ck_max(TRAS_MAX_NS) - 1);
    localparam cnt_t RC_CK      = cnt_t'(ns_to_ck_min(TRC_NS));
    localparam cnt_t RCD_CK     = cnt_t'(ns_to_ck_min(TRCD_NS));
    localparam cnt_t RAP_CK     = cnt_t'(ns_to_ck_min(TRAP_NS));
    localparam cnt_t RRD_CK     = cnt_t'(ns_to_ck_min(TRRD_NS));
    localparam cnt_t MRD_CK     = cnt_t'(ns_to_ck_min(TMRD_NS));
    localparam cnt_t RFC_CK     = cnt_t'(ns_to_ck_min(BIG_MODULE ? TRFC_BIG_NS : TRFC_SMALL_NS));
    localparam cnt_t WTR_CK     = cnt_t'(TWTR_CK);
    // Average interval, far inside the hard refresh limit
    localparam cnt_t REFI_CK    = cnt_t'(ns_to_ck_max(TREFI_NS));
    localparam cnt_t REFC_CK    = cnt_t'(ns_to_ck_max(TREFC_MAX_NS));
    localparam logic [STEP_W-1:0] STEP_ONE   = STEP_W'(1);
    localparam logic [STEP_W-1:0] STEP_PRE   = STEP_W'(STEP_PREAMBLE);
    localparam logic [STEP_W-1:0] STEP_BEAT  = STEP_W'(STEP_FIRST);
    localparam logic [STEP_W-1:0] STEP_END   = STEP_W'(BURST_LEN + STEP_FIRST);
    localparam logic [STEP_W-1:0] STEP_LAST  = STEP_W'(BURST_LEN + STEP_FIRST - 1);

    typedef struct packed {
        logic                       ck;
        logic                       ck_n;
        logic                       cke;
        logic                       accept;
        cmd_pins_s                  pins;
        logic [BANK_W-1:0]          ba;
        logic [ADDR_W-1:0]          addr;
        logic                       dqs;
        logic                       dqs_oe;
        logic [STEP_W-1:0]          wstep;
        logic [NUM_BANKS-1:0]       open;
        logic [NUM_BANKS-1:0][CNT_W-1:0] ras_min;
        logic [NUM_BANKS-1:0][CNT_W-1:0] ras_max;
        logic [NUM_BANKS-1:0][CNT_W-1:0] rc;
        logic [NUM_BANKS-1:0][CNT_W-1:0] rcd;
        logic [NUM_BANKS-1:0][CNT_W-1:0] rap;
        cnt_t                       rrd;
        cnt_t                       rfc;
        cnt_t                       mrd;
        cnt_t                       wtr;
        cnt_t                       ref_timer;
        logic                       ref_due;
    } state_s;

    state_s st_reg;
    state_s st_next;

    function automatic cnt_t dec(input cnt_t v);
        return (v == '0) ? v : v - cnt_t'(1);
    endfunction : dec

    always_comb begin
        logic                all_closed;
        logic                all_rc_done;
        logic                all_ras_done;
        logic                exp_hit;
        logic [BANK_W-1:0]   exp_bank;
        logic                legal;
        int                  b;
        all_closed   = 1'b1;
        all_rc_done  = 1'b1;
        all_ras_done = 1'b1;
        exp_hit      = 1'b0;
        exp_bank     = '0;
        legal        = 1'b0;
        b            = 0;
        st_next      = st_reg;
        st_next.ck     = ~st_reg.ck;
        st_next.ck_n   = st_reg.ck;
        st_next.cke    = 1'b1;
        st_next.accept = 1'b0;
        // Counters tick on rising memory clock, decisions are made on falling
        if (!st_reg.ck) begin
            for (int i = 0; i < NUM_BANKS; i++) begin
                st_next.ras_min[i] = dec(st_reg.ras_min[i]);
                st_next.ras_max[i] = dec(st_reg.ras_max[i]);
                st_next.rc[i]      = dec(st_reg.rc[i]);
                st_next.rcd[i]     = dec(st_reg.rcd[i]);
                st_next.rap[i]     = dec(st_reg.rap[i]);
            end
            st_next.rrd = dec(st_reg.rrd);
            st_next.rfc = dec(st_reg.rfc);
            st_next.mrd = dec(st_reg.mrd);
            st_next.wtr = dec(st_reg.wtr);
            st_next.ref_timer = dec(st_reg.ref_timer);
            if (st_reg.ref_timer == '0) begin
                st_next.ref_due = 1'b1;                                       // R11
            end
        end
        if (st_reg.wstep != '0) begin
            st_next.wstep = (st_reg.wstep == STEP_END) ? '0 : st_reg.wstep + STEP_ONE;
        end
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (st_reg.open[i]) begin
                all_closed = 1'b0;
                if (st_reg.ras_max[i] == '0 && !exp_hit) begin
                    exp_hit  = 1'b1;
                    exp_bank = BANK_W'(i);
                end
            end
            if (st_reg.rc[i] != '0) begin
                all_rc_done = 1'b0;
            end
            if (st_reg.open[i] && st_reg.ras_min[i] != '0) begin
                all_ras_done = 1'b0;
            end
        end
        if (st_reg.ck) begin
            st_next.pins = PINS_NOP;
            b = int'(req_in.bank);
            if (st_reg.rfc != '0 || st_reg.mrd != '0) begin
                st_next.pins = PINS_NOP;                                      // R3 R7
            end else if (exp_hit) begin
                st_next.pins = PINS_PRE;                                      // R1
                st_next.ba   = exp_bank;
                st_next.addr = '0;
                st_next.open[exp_bank] = 1'b0;
            end else if (st_reg.ref_due) begin
                // Refresh outranks requests, so it is never postponed
                if (!all_closed) begin
                    if (all_ras_done) begin
                        st_next.pins = PINS_PRE;                              // R1
                        st_next.addr = ADDR_W'(1) << AP_BIT;
                        st_next.open = '0;
                    end
                end else if (all_rc_done) begin
                    st_next.pins      = PINS_REFRESH;                         // R2 R11
                    st_next.rfc       = RFC_CK;                               // R3
                    st_next.ref_due   = 1'b0;
                    st_next.ref_timer = REFI_CK;
                end
            end else if (req_in.valid) begin
                unique case (req_in.op)
                    OP_NOP:       legal = 1'b1;
                    OP_ACT:       legal = !st_reg.open[b] && st_reg.rc[b] == '0
                                          && st_reg.rrd == '0;                // R2 R6
                    OP_READ:      legal = st_reg.open[b] && st_reg.rcd[b] == '0
                                          && st_reg.wtr == '0
                                          && st_reg.wstep == '0;              // R4 R12
                    OP_READ_AP:   legal = st_reg.open[b] && st_reg.rap[b] == '0
                                          && st_reg.rcd[b] == '0 && st_reg.wtr == '0
                                          && st_reg.wstep == '0;              // R5 R12
                    OP_WRITE:     legal = st_reg.open[b] && st_reg.rcd[b] == '0
                                          && st_reg.wstep == '0;              // R4
                    OP_PRE:       legal = !st_reg.open[b] || st_reg.ras_min[b] == '0; // R1
                    OP_REFRESH:   legal = all_closed && all_rc_done;          // R2
                    OP_LOAD_MODE: legal = all_closed;
                endcase
                if (legal) begin
                    st_next.accept = 1'b1;
                    st_next.ba     = req_in.bank;
                    st_next.addr   = req_in.addr;
                    unique case (req_in.op)
                        OP_NOP: st_next.pins = PINS_NOP;
                        OP_ACT: begin
                            st_next.pins       = PINS_ACT;
                            st_next.open[b]    = 1'b1;
                            st_next.ras_min[b] = RAS_MIN_CK;                  // R1
                            st_next.ras_max[b] = RAS_MAX_CK;                  // R1
                            st_next.rc[b]      = RC_CK;                       // R2
                            st_next.rcd[b]     = RCD_CK;                      // R4
                            st_next.rap[b]     = RAP_CK;                      // R5
                            st_next.rrd        = RRD_CK;                      // R6
                        end
                        OP_READ: begin
                            st_next.pins         = PINS_READ;
                            st_next.addr[AP_BIT] = 1'b0;
                        end
                        OP_READ_AP: begin
                            st_next.pins         = PINS_READ;
                            st_next.addr[AP_BIT] = 1'b1;
                            st_next.open[b]      = 1'b0;
                        end
                        OP_WRITE: begin
                            st_next.pins         = PINS_WRITE;
                            st_next.addr[AP_BIT] = 1'b0;
                            st_next.wstep        = STEP_ONE;
                        end
                        OP_PRE: begin
                            st_next.pins         = PINS_PRE;
                            st_next.addr[AP_BIT] = 1'b0;
                            st_next.open[b]      = 1'b0;
                        end
                        OP_REFRESH: begin
                            st_next.pins      = PINS_REFRESH;
                            st_next.rfc       = RFC_CK;                       // R3
                            st_next.ref_timer = REFI_CK;                      // R11
                        end
                        OP_LOAD_MODE: begin
                            st_next.pins = PINS_LMR;
                            st_next.mrd  = MRD_CK;                            // R7
                        end
                    endcase
                end
            end
        end
        // Preamble from the falling clock after WRITE, first rise half a clock later, one full clock after WRITE
        st_next.dqs_oe = st_next.wstep >= STEP_PRE && st_next.wstep <= STEP_END;  // R10
        // Strobe rises sit on clock rises, strobe falls on clock falls, half a clock from each rising edge
        st_next.dqs = st_next.wstep >= STEP_BEAT && st_next.wstep < STEP_END
                      && !st_next.wstep[0];                                   // R8 R9
        if (st_next.wstep == STEP_LAST) begin
            st_next.wtr = WTR_CK;                                             // R12
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_reg           <= '0;
            st_reg.pins      <= PINS_NOP;
            st_reg.ref_timer <= REFI_CK;
        end else begin
            st_reg <= st_next;
        end
    end

    assign req_ready_out = st_reg.accept;
    assign ck_out        = st_reg.ck;
    assign ck_n_out      = st_reg.ck_n;
    assign cke_out       = st_reg.cke;
    assign cmd_out       = st_reg.pins;
    assign ba_out        = st_reg.ba;
    assign addr_out      = st_reg.addr;
    assign dqs_out       = st_reg.dqs;
    assign dqs_oe_out    = st_reg.dqs_oe;

endmodule : ddr_cmd_timer

// [inc/ddr_timing_pkg.sv]
package ddr_timing_pkg;

    // Clocking: the memory clock is the system clock divided by two
    localparam int MCLK_NS    = 100;
    localparam int CK_DIV     = 2;
    localparam int TCK_NS     = MCLK_NS * CK_DIV;

    localparam int NUM_BANKS  = 4;
    localparam int BANK_W     = 2;
    localparam int ADDR_W     = 14;
    localparam int CNT_W      = 9;
    localparam int STEP_W     = 5;
    localparam int AP_BIT     = 10;

    // Command spacing figures in nanoseconds, TWTR_CK in clocks, then the default burst length
    localparam int TRAS_MIN_NS   = 40;
    localparam int TRAS_MAX_NS   = 70000;
    localparam int TRC_NS        = 55;
    localparam int TRFC_SMALL_NS = 70;
    localparam int TRFC_BIG_NS   = 120;
    localparam int TRCD_NS       = 15;
    localparam int TRAP_NS       = 15;
    localparam int TRRD_NS       = 10;
    localparam int TMRD_NS       = 2;
    localparam int TREFI_NS      = 7800;
    localparam int TREFC_MAX_NS  = 70300;
    localparam int TWTR_CK       = 2;
    localparam int BURST_LEN_DEF = 4;

    // Least times round up, longest times round down, never below one cycle
    function automatic int ns_to_ck_min(input int ns);
        int c;
        c = (ns + TCK_NS - 1) / TCK_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_ck_min

    function automatic int ns_to_ck_max(input int ns);
        int c;
        c = ns / TCK_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_ck_max

    typedef enum logic [2:0] {
        OP_NOP       = 3'h0,
        OP_ACT       = 3'h1,
        OP_READ      = 3'h2,
        OP_READ_AP   = 3'h3,
        OP_WRITE     = 3'h4,
        OP_PRE       = 3'h5,
        OP_REFRESH   = 3'h6,
        OP_LOAD_MODE = 3'h7
    } op_e;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } cmd_pins_s;

    localparam cmd_pins_s PINS_NOP     = 4'h7;
    localparam cmd_pins_s PINS_ACT     = 4'h3;
    localparam cmd_pins_s PINS_READ    = 4'h5;
    localparam cmd_pins_s PINS_WRITE   = 4'h4;
    localparam cmd_pins_s PINS_PRE     = 4'h2;
    localparam cmd_pins_s PINS_REFRESH = 4'h1;
    localparam cmd_pins_s PINS_LMR     = 4'h0;

    typedef struct packed {
        logic              valid;
        op_e               op;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } req_s;

    // Write strobe steps, counted in system clocks from the issue edge
    localparam int STEP_PREAMBLE = 3;
    localparam int STEP_FIRST    = 4;

endpackage : ddr_timing_pkg

// [sim/ddr_cmd_timer_bench.sv]
`timescale 1ns/1ns
module ddr_cmd_timer_bench;
    import ddr_timing_pkg::*;
    logic              mclk_in, resetn_in, req_ready_out, ck_out, ck_n_out, cke_out;
    logic              dqs_out, dqs_oe_out, dqs_in;
    req_s              req_in;
    cmd_pins_s         cmd_out;
    logic [BANK_W-1:0] ba_out;
    logic [ADDR_W-1:0] addr_out;
    logic [15:0]       violations;
    int                miscompares = 0, samples_checked = 0, cycles = 0, n_ref = 0;
    // Strobe enable and level seen at the falls after WRITE is taken
    localparam logic [7:0] STROBE_OE = 8'h7e;
    localparam logic [7:0] STROBE_HI = 8'h14;
    ddr_cmd_timer uut (.mclk_in(mclk_in), .resetn_in(resetn_in), .req_in(req_in),
        .req_ready_out(req_ready_out), .ck_out(ck_out), .ck_n_out(ck_n_out), .cke_out(cke_out),
        .cmd_out(cmd_out), .ba_out(ba_out), .addr_out(addr_out), .dqs_out(dqs_out),
        .dqs_oe_out(dqs_oe_out), .dqs_in(dqs_in));
    ddr_module_model partner (.ck_in(ck_out), .cmd_in(cmd_out), .ba_in(ba_out),
        .addr_in(addr_out), .dqs_in(dqs_out), .dqs_oe_in(dqs_oe_out), .strobe_out(dqs_in),
        .violations_out(violations));
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    task automatic final_report;
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    always @(posedge mclk_in) begin
        cycles++;
        if (!ck_out && cmd_out == PINS_REFRESH) n_ref++;
        // Whole run is near 1,070 cycles
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Refused requests are given a short wait only
    // Leading fall keeps valid low for one edge, costs no decision slot
    task automatic send(input op_e op, input int bank, input logic ap, input bit take,
                        output int w);
        @(negedge mclk_in);
        req_in = '{1'b1, op, bank[1:0], {3'h0, ap, 10'h0}};
        w = 0;
        do begin
            @(negedge mclk_in);
            w++;
        end while (!req_ready_out && w < (take ? 300 : 16));
        check(req_ready_out, take);
        req_in.valid = 1'b0;
    endtask : send
    // Refresh closes every row, so scenarios start just after one
    task automatic sync_ref;
        int n;
        n = n_ref;
        while (n_ref == n) @(negedge mclk_in);
        repeat (6) @(negedge mclk_in);
    endtask : sync_ref
    task automatic write_read;
        int w;
        sync_ref();
        send(OP_ACT, 1, 1'b0, 1'b1, w);
        send(OP_WRITE, 1, 1'b0, 1'b1, w);
        fork
            for (int k = 0; k < 8; k++) begin
                @(negedge mclk_in);
                check({dqs_oe_out, dqs_oe_out & dqs_out}, {STROBE_OE[k], STROBE_HI[k]});
            end
            begin
                repeat (2) @(negedge mclk_in);
                send(OP_READ, 1, 1'b0, 1'b1, w);
                check(w >= 7, 1);
            end
        join
        send(OP_READ_AP, 1, 1'b1, 1'b1, w);
        send(OP_READ, 1, 1'b0, 1'b0, w);
    endtask : write_read
    task automatic banks;
        int w;
        sync_ref();
        for (int b = 0; b < 4; b++) send(OP_ACT, b, 1'b0, 1'b1, w);
        send(OP_ACT, 2, 1'b0, 1'b0, w);
        send(OP_REFRESH, 0, 1'b0, 1'b0, w);
        send(OP_PRE, 0, 1'b1, 1'b1, w);
        send(OP_LOAD_MODE, 0, 1'b0, 1'b1, w);
        send(OP_REFRESH, 0, 1'b0, 1'b1, w);
    endtask : banks
    task automatic refresh_rate;
        int n;
        int w;
        send(OP_ACT, 3, 1'b0, 1'b1, w);
        n = n_ref;
        repeat (800) @(negedge mclk_in);
        check(n_ref - n >= 8, 1);
        send(OP_WRITE, 3, 1'b0, 1'b0, w);
    endtask : refresh_rate
    initial begin
        resetn_in = 1'b0;
        req_in = '0;
        repeat (6) @(negedge mclk_in);
        check({cke_out, dqs_oe_out, cmd_out}, {2'h0, PINS_NOP});
        resetn_in = 1'b1;
        @(negedge mclk_in);
        check({cke_out, ck_out, ck_n_out}, 3'h6);
        @(negedge mclk_in);
        check({cke_out, ck_out, ck_n_out}, 3'h5);
        write_read();
        banks();
        refresh_rate();
        check(violations, 16'h0);
        final_report();
    end
endmodule : ddr_cmd_timer_bench

// [sim/ddr_cmd_timer_sva.sv]
`timescale 1ns/1ns
module ddr_cmd_timer_sva
    import ddr_timing_pkg::*;
#(
    parameter int BURST_LEN  = 4,
    parameter bit BIG_MODULE = 1'b0
) (
    input wire logic                      mclk_in,
    input wire logic                      resetn_in,
    input wire logic                      ck_out,
    input wire ddr_timing_pkg::cmd_pins_s cmd_out,
    input wire logic [BANK_W-1:0]         ba_out,
    input wire logic [ADDR_W-1:0]         addr_out,
    input wire logic                      dqs_out,
    input wire logic                      dqs_oe_out
);
    typedef struct packed {
        logic [3:0]  open_b;
        logic [10:0] ref_gap;
        logic [3:0]  wr_gap;
    } track_s;
    track_s st_reg;
    track_s st_next;
    logic   issue;
    logic   ap;
    // A command is counted once, in its first cycle after the fall edge
    assign issue = !ck_out && !cmd_out.cs_n;
    assign ap = addr_out[AP_BIT];
    always_comb begin
        st_next = st_reg;
        st_next.ref_gap = st_reg.ref_gap + 11'h1;
        if (st_reg.wr_gap != 4'hf) st_next.wr_gap = st_reg.wr_gap + 4'h1;
        if (issue && cmd_out == PINS_ACT) st_next.open_b[ba_out] = 1'b1;
        if (issue && cmd_out.ras_n && !cmd_out.cas_n && ap) st_next.open_b[ba_out] = 1'b0;
        if (issue && cmd_out == PINS_PRE && ap) st_next.open_b = 4'h0;
        if (issue && cmd_out == PINS_PRE && !ap) st_next.open_b[ba_out] = 1'b0;
        if (issue && cmd_out == PINS_REFRESH) st_next.ref_gap = 11'h0;
        if (issue && cmd_out == PINS_WRITE) st_next.wr_gap = 4'h0;
    end
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) st_reg <= {4'h0, 11'h0, 4'hf};
        else st_reg <= st_next;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    rw_open_bank_a: assert property (issue && cmd_out.ras_n && !cmd_out.cas_n
        |-> st_reg.open_b[ba_out]) else $error("access to closed bank");
    act_idle_bank_a: assert property (issue && cmd_out == PINS_ACT
        |-> !st_reg.open_b[ba_out]) else $error("activate to open bank");
    ref_all_idle_a: assert property (issue && !cmd_out.ras_n && !cmd_out.cas_n
        |-> st_reg.open_b == 4'h0) else $error("refresh with bank open");
    refresh_gap_a: assert property (st_reg.ref_gap < 11'h2c0)
        else $error("refresh interval too long");
    strobe_first_a: assert property (issue && cmd_out == PINS_WRITE |-> ##2
        (dqs_oe_out && !dqs_out) ##1 (dqs_oe_out && dqs_out)) else $error("strobe misplaced");
    strobe_rise_a: assert property (dqs_oe_out && $rose(dqs_out) |-> ck_out)
        else $error("strobe rise off clock rise");
    strobe_fall_a: assert property (dqs_oe_out && $fell(dqs_out) |-> !ck_out)
        else $error("strobe fall near clock rise");
    wtr_gap_a: assert property (issue && cmd_out == PINS_READ |-> st_reg.wr_gap > 4'h8)
        else $error("read too soon after write");
    cmd_on_fall_a: assert property ($changed(cmd_out) |-> !ck_out)
        else $error("command off clock boundary");
endmodule : ddr_cmd_timer_sva

bind ddr_cmd_timer ddr_cmd_timer_sva #(.BURST_LEN(BURST_LEN), .BIG_MODULE(BIG_MODULE)) chk (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .ck_out(ck_out), .cmd_out(cmd_out),
    .ba_out(ba_out), .addr_out(addr_out), .dqs_out(dqs_out), .dqs_oe_out(dqs_oe_out));

// [sim/ddr_module_model.sv]
`timescale 1ns/1ns
module ddr_module_model
    import ddr_timing_pkg::*;
#(
    parameter bit BIG_MODULE = 1'b0
) (
    input  wire logic                      ck_in,
    input  wire ddr_timing_pkg::cmd_pins_s cmd_in,
    input  wire logic [BANK_W-1:0]         ba_in,
    input  wire logic [ADDR_W-1:0]         addr_in,
    input  wire logic                      dqs_in,
    input  wire logic                      dqs_oe_in,
    output logic                           strobe_out,
    output logic [15:0]                    violations_out
);
    longint act_t [NUM_BANKS] = '{default: 0};
    longint act_any = 0, ref_t = 0, lmr_t = 0, wr_t = 0, pre_t = 0, rise_t = 0, fall_t = 0;
    logic [NUM_BANKS-1:0] open_b = '0;
    initial violations_out = 16'h0;
    // Released strobe shows a moving pattern, never a stale level
    assign strobe_out = dqs_oe_in ? dqs_in : ~ck_in;
    task automatic need(input bit ok);
        if (!ok) violations_out = violations_out + 16'h1;
    endtask : need
    always @(posedge ck_in) begin
        rise_t = $time;
        need(5 * ($time - fall_t) >= TCK_NS);
        need($time - ref_t <= 70300);
        for (int b = 0; b < NUM_BANKS; b++) need(!open_b[b] || $time - act_t[b] <= 70000);
        if (!cmd_in.cs_n) need($time - ref_t >= (BIG_MODULE ? 120 : 70) && $time - lmr_t >= 2);
        case (cmd_in)
            PINS_ACT: begin
                need(!open_b[ba_in] && $time - act_t[ba_in] >= 55 && $time - act_any >= 10);
                open_b[ba_in] = 1'b1;
                act_t[ba_in] = $time;
                act_any = $time;
            end
            PINS_READ, PINS_WRITE: begin
                need(open_b[ba_in] && $time - act_t[ba_in] >= 15);
                if (cmd_in.we_n) need($time - fall_t >= 2 * TCK_NS);
                else wr_t = $time;
                if (addr_in[AP_BIT]) open_b[ba_in] = 1'b0;
            end
            PINS_PRE, PINS_REFRESH: begin
                for (int b = 0; b < NUM_BANKS; b++) begin
                    if (cmd_in.we_n) need(!open_b[b] && $time - act_t[b] >= 55);
                    else if (open_b[b] && (addr_in[AP_BIT] || ba_in == b)) begin
                        need($time - act_t[b] >= 40);
                        open_b[b] = 1'b0;
                    end
                end
                if (cmd_in.we_n) ref_t = $time;
            end
            PINS_LMR: lmr_t = $time;
            default: ;
        endcase
    end
    always @(posedge dqs_oe_in) begin
        need($time >= wr_t && !dqs_in);
        pre_t = $time;
    end
    always @(posedge dqs_in) begin
        if (dqs_oe_in && $time - wr_t < 2 * TCK_NS) begin
            need(100 * ($time - wr_t) >= 72 * TCK_NS && 100 * ($time - wr_t) <= 128 * TCK_NS);
            need(4 * ($time - pre_t) >= TCK_NS);
        end
    end
    always @(negedge dqs_in) begin
        if (dqs_oe_in) begin
            need(5 * ($time - rise_t) >= TCK_NS);
            fall_t = $time;
        end
    end
endmodule : ddr_module_model
